// file: hdl/led_duty_defines.svh
`ifndef LED_DUTY_DEFINES_SVH
`define LED_DUTY_DEFINES_SVH

`define ADDR_PULSE1_DUTY 8'h90
`define ADDR_PULSE2_DUTY 8'h91
`define ADDR_BREATHE_DUTY 8'h92
`define ADDR_DIRECT_DUTY 8'h93
`define ADDR_RAMP_TIMES 8'h94
`define ADDR_OFF_DELAY 8'h95

`define RST_PULSE1_DUTY 8'hF0
`define RST_PULSE2_DUTY 8'hF0
`define RST_BREATHE_DUTY 8'hF0
`define RST_DIRECT_DUTY 8'hF0
`define RST_RAMP_TIMES 8'h00
`define RST_OFF_DELAY 8'h00

`define UPPER_DUTY_MSB 7
`define UPPER_DUTY_LSB 4
`define LOWER_DUTY_MSB 3
`define LOWER_DUTY_LSB 0
`define RISE_SEL_MSB 5
`define RISE_SEL_LSB 3
`define FALL_SEL_MSB 2
`define FALL_SEL_LSB 0
`define OFF_DELAY_MSB 2
`define OFF_DELAY_LSB 0

`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000000
`define BREATHE_HALF_MS 1000
`define PWM_STEPS 100
`define PWM_SLOW_DIV 8

`endif

// file: hdl/led_duty_pkg.sv
package led_duty_pkg;

    typedef logic [6:0] percent_t;
    typedef logic [12:0] msec_t;

    typedef enum logic [1:0]
    {
        BEH_DIRECT = 2'h0,
        BEH_PULSE1 = 2'h1,
        BEH_PULSE2 = 2'h2,
        BEH_BREATHE = 2'h3
    } behaviour_e;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_RISE = 3'h1,
        ST_HOLD = 3'h3,
        ST_DELAY = 3'h2,
        ST_FALL = 3'h6
    } ramp_state_e;

endpackage : led_duty_pkg

// file: hdl/pwm_link_if.sv
`timescale 1ns/1ps

interface pwm_link_if;
    import led_duty_pkg::*;
    percent_t duty;
    logic fastMode;

    modport src
    (
        output duty,
        output fastMode
    );
    modport sink
    (
        input duty,
        input fastMode
    );
endinterface : pwm_link_if

// file: hdl/pwm_core.sv
`timescale 1ns/1ps
`include "led_duty_defines.svh"

module pwm_core
    import led_duty_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    pwm_link_if.sink link,
    output logic pwmOut
);
    logic [6:0] slotCnt_reg;
    logic [3:0] divCnt_reg;
    logic slotAdvance;

    // Slow PWM frame when any ramp time is set, full rate otherwise
    assign slotAdvance = link.fastMode || (divCnt_reg == 4'(`PWM_SLOW_DIV - 1));

    always_ff @(posedge clock)
    begin
        if (!nrst || slotAdvance)
            divCnt_reg <= 4'h0;
        else
            divCnt_reg <= divCnt_reg + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            slotCnt_reg <= 7'h00;
        else if (slotAdvance)
            slotCnt_reg <= (slotCnt_reg == 7'(`PWM_STEPS - 1)) ? 7'h00 : slotCnt_reg + 7'h01;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            pwmOut <= 1'b0;
        else
            pwmOut <= (slotCnt_reg < link.duty);
    end

    chk_pwm_full_on: assert property (@(posedge clock) disable iff (!nrst)
        (link.duty == 7'(`PWM_STEPS)) [*3] |-> pwmOut)
        else $error("pwm not fully on at full duty");
    chk_pwm_zero_off: assert property (@(posedge clock) disable iff (!nrst)
        (link.duty == 7'h00) [*3] |-> !pwmOut)
        else $error("pwm not off at zero duty");

endmodule : pwm_core

// file: hdl/led_duty_ramp.sv
`timescale 1ns/1ps
`include "led_duty_defines.svh"

module led_duty_ramp
    import led_duty_pkg::*;
#(
    parameter int MS_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    output logic [7:0] regRdData,
    input wire logic [1:0] behaviour,
    input wire logic actuate,
    input wire logic byDriveBit,
    input wire logic rampAlertEn,
    output logic pwmOut,
    output logic [6:0] dutyLevel,
    output logic alert
);
    logic [7:0] dutyLimits_reg [4];
    logic [7:0] rampTimes_reg;
    logic [7:0] offDelay_reg;
    ramp_state_e state_reg;
    behaviour_e beh_reg;
    percent_t latchedLo_reg, latchedHi_reg, duty_reg;
    msec_t acc_reg, msCnt_reg;
    logic [17:0] tickCnt_reg;
    logic actPrev_reg, drivenRun_reg;
    logic msTick, isDirect, atTop, atBottom;
    percent_t lo, hi, liveLo, liveHi, span;
    msec_t riseMs, fallMs, offMs, rampMs;
    logic [13:0] accSum;
    pwm_link_if link ();

    function automatic percent_t upperPct(input logic [3:0] code);
        case (code)
            4'h0: upperPct = 7'd7;
            4'h1: upperPct = 7'd9;
            4'h2: upperPct = 7'd11;
            4'h3: upperPct = 7'd14;
            4'h4: upperPct = 7'd17;
            4'h5: upperPct = 7'd20;
            4'h6: upperPct = 7'd23;
            4'h7: upperPct = 7'd26;
            4'h8: upperPct = 7'd30;
            4'h9: upperPct = 7'd35;
            4'hA: upperPct = 7'd40;
            4'hB: upperPct = 7'd46;
            4'hC: upperPct = 7'd53;
            4'hD: upperPct = 7'd63;
            4'hE: upperPct = 7'd77;
            default: upperPct = 7'd100;
        endcase
    endfunction : upperPct

    // Lower table is the upper table shifted by one code
    function automatic percent_t lowerPct(input logic [3:0] code);
        lowerPct = (code == 4'h0) ? 7'd0 : upperPct(code - 4'h1);
    endfunction : lowerPct

    function automatic msec_t rampTimeMs(input logic [2:0] code);
        rampTimeMs = (code == 3'h7) ? 13'd2000 : 13'(code * 250);
    endfunction : rampTimeMs

    function automatic msec_t offDelayMs(input logic [2:0] code);
        offDelayMs = (code <= 3'h4) ? 13'(code * 500) : 13'((code - 3'h2) * 1000);
    endfunction : offDelayMs

    assign riseMs = rampTimeMs(rampTimes_reg[`RISE_SEL_MSB:`RISE_SEL_LSB]);
    assign fallMs = rampTimeMs(rampTimes_reg[`FALL_SEL_MSB:`FALL_SEL_LSB]);
    assign offMs = offDelayMs(offDelay_reg[`OFF_DELAY_MSB:`OFF_DELAY_LSB]);
    assign liveLo = lowerPct(dutyLimits_reg[behaviour][`LOWER_DUTY_MSB:`LOWER_DUTY_LSB]);
    assign liveHi = upperPct(dutyLimits_reg[behaviour][`UPPER_DUTY_MSB:`UPPER_DUTY_LSB]);
    assign isDirect = (beh_reg == BEH_DIRECT);
    // Direct follows live limits, other modes hold the captured ones
    assign lo = isDirect ? lowerPct(dutyLimits_reg[0][3:0]) : latchedLo_reg;
    assign hi = isDirect ? upperPct(dutyLimits_reg[0][7:4]) : latchedHi_reg;
    assign span = (hi > lo) ? hi - lo : 7'd0;
    assign rampMs = !isDirect ? 13'(`BREATHE_HALF_MS) : (state_reg == ST_FALL) ? fallMs : riseMs;
    assign accSum = {1'b0, acc_reg} + {7'h00, span};
    assign atTop = (duty_reg >= hi);
    assign atBottom = (duty_reg <= lo);
    assign msTick = (tickCnt_reg == 18'(MS_CYCLES - 1));

    always_ff @(posedge clock)
    begin
        if (!nrst || msTick)
            tickCnt_reg <= 18'h00000;
        else
            tickCnt_reg <= tickCnt_reg + 18'h00001;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            dutyLimits_reg[0] <= `RST_DIRECT_DUTY;
            dutyLimits_reg[1] <= `RST_PULSE1_DUTY;
            dutyLimits_reg[2] <= `RST_PULSE2_DUTY;
            dutyLimits_reg[3] <= `RST_BREATHE_DUTY;
            rampTimes_reg <= `RST_RAMP_TIMES;
            offDelay_reg <= `RST_OFF_DELAY;
        end
        else if (regWrEn)
        begin
            case (regAddr)
                `ADDR_PULSE1_DUTY: dutyLimits_reg[1] <= regWrData;
                `ADDR_PULSE2_DUTY: dutyLimits_reg[2] <= regWrData;
                `ADDR_BREATHE_DUTY: dutyLimits_reg[3] <= regWrData;
                `ADDR_DIRECT_DUTY: dutyLimits_reg[0] <= regWrData;
                `ADDR_RAMP_TIMES: rampTimes_reg <= {2'h0, regWrData[5:0]};
                `ADDR_OFF_DELAY: offDelay_reg <= {5'h00, regWrData[2:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            regRdData <= 8'h00;
        else
        begin
            case (regAddr)
                `ADDR_PULSE1_DUTY: regRdData <= dutyLimits_reg[1];
                `ADDR_PULSE2_DUTY: regRdData <= dutyLimits_reg[2];
                `ADDR_BREATHE_DUTY: regRdData <= dutyLimits_reg[3];
                `ADDR_DIRECT_DUTY: regRdData <= dutyLimits_reg[0];
                `ADDR_RAMP_TIMES: regRdData <= rampTimes_reg;
                `ADDR_OFF_DELAY: regRdData <= offDelay_reg;
                default: regRdData <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            actPrev_reg <= 1'b0;
        else
            actPrev_reg <= actuate;
    end

    // Mode and limits captured on each new actuation from idle
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            beh_reg <= BEH_DIRECT;
            latchedLo_reg <= 7'd0;
            latchedHi_reg <= 7'd100;
            drivenRun_reg <= 1'b0;
        end
        else if (state_reg == ST_IDLE && actuate && !actPrev_reg)
        begin
            beh_reg <= behaviour_e'(behaviour);
            latchedLo_reg <= liveLo;
            latchedHi_reg <= liveHi;
            drivenRun_reg <= byDriveBit;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
            duty_reg <= 7'd0;
            acc_reg <= 13'h0000;
            msCnt_reg <= 13'h0000;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    duty_reg <= (actuate && !actPrev_reg) ? liveLo : lo;
                    acc_reg <= 13'h0000;
                    if (actuate && !actPrev_reg)
                        state_reg <= ST_RISE;
                end
                ST_RISE:
                begin
                    if (rampMs == 13'h0000 || atTop)
                    begin
                        duty_reg <= hi;
                        acc_reg <= 13'h0000;
                        state_reg <= isDirect ? ST_HOLD : ST_FALL;
                    end
                    else if (msTick)
                    begin
                        if (accSum >= {1'b0, rampMs})
                        begin
                            duty_reg <= duty_reg + 7'd1;
                            acc_reg <= 13'(accSum - {1'b0, rampMs});
                        end
                        else
                            acc_reg <= accSum[12:0];
                    end
                end
                ST_HOLD:
                begin
                    duty_reg <= hi;
                    msCnt_reg <= 13'h0000;
                    if (!actuate)
                        state_reg <= ST_DELAY;
                end
                ST_DELAY:
                begin
                    duty_reg <= hi;
                    if (actuate)
                        state_reg <= ST_HOLD;
                    else if (msCnt_reg >= offMs)
                        state_reg <= ST_FALL;
                    else if (msTick)
                        msCnt_reg <= msCnt_reg + 13'h0001;
                end
                ST_FALL:
                begin
                    if (rampMs == 13'h0000 || atBottom)
                    begin
                        duty_reg <= lo;
                        acc_reg <= 13'h0000;
                        state_reg <= (!isDirect && actuate) ? ST_RISE : ST_IDLE;
                    end
                    else if (isDirect && actuate)
                        state_reg <= ST_RISE;
                    else if (msTick)
                    begin
                        if (accSum >= {1'b0, rampMs})
                        begin
                            duty_reg <= duty_reg - 7'd1;
                            acc_reg <= 13'(accSum - {1'b0, rampMs});
                        end
                        else
                            acc_reg <= accSum[12:0];
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            alert <= 1'b0;
        else
            alert <= rampAlertEn && drivenRun_reg && state_reg == ST_FALL
                && (rampMs == 13'h0000 || atBottom) && !(!isDirect && actuate);
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            dutyLevel <= 7'd0;
        else
            dutyLevel <= duty_reg;
    end

    assign link.duty = duty_reg;
    assign link.fastMode = (rampTimes_reg[5:0] == 6'h00);

    pwm_core u_pwm
    (
        .clock(clock),
        .nrst(nrst),
        .link(link),
        .pwmOut(pwmOut)
    );

    chk_rise_monotonic: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg == ST_RISE && $past(state_reg) == ST_RISE) |-> duty_reg >= $past(duty_reg))
        else $error("duty fell during rise");
    chk_fall_monotonic: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg == ST_FALL && $past(state_reg) == ST_FALL) |-> duty_reg <= $past(duty_reg))
        else $error("duty rose during fall");
    chk_hold_at_upper: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg == ST_HOLD) ##1 (state_reg == ST_HOLD) |-> duty_reg == $past(hi))
        else $error("hold duty not upper limit");
    chk_direct_live_write: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg == ST_HOLD && isDirect && regWrEn && regAddr == `ADDR_DIRECT_DUTY
        && !$past(!actuate)) ##1 (state_reg == ST_HOLD) [*2] |-> duty_reg == hi)
        else $error("direct write not applied at once");
    chk_latched_limits: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg != ST_IDLE && $past(state_reg) != ST_IDLE)
        |-> latchedHi_reg == $past(latchedHi_reg))
        else $error("captured limit changed mid run");
    chk_delay_before_fall: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg == ST_DELAY ##1 state_reg == ST_FALL) |-> $past(msCnt_reg) >= $past(offMs))
        else $error("fall began before off delay");
    chk_direct_sequence: assert property (@(posedge clock) disable iff (!nrst)
        (isDirect && state_reg == ST_RISE ##1 state_reg != ST_RISE) |-> state_reg == ST_HOLD)
        else $error("direct rise not followed by hold");
    chk_zero_rise_jump: assert property (@(posedge clock) disable iff (!nrst)
        (isDirect && state_reg == ST_IDLE && actuate && !actPrev_reg && riseMs == 13'h0000)
        ##1 (isDirect && state_reg == ST_RISE && riseMs == 13'h0000) |=> duty_reg == $past(hi))
        else $error("zero rise time not immediate");
    chk_alert_gated: assert property (@(posedge clock) disable iff (!nrst)
        alert |-> $past(rampAlertEn) && $past(drivenRun_reg))
        else $error("alert without enable or drive bit");

    cov_direct_fall: cover property (@(posedge clock) disable iff (!nrst)
        state_reg == ST_DELAY ##1 state_reg == ST_FALL);
    cov_breathe_cycle: cover property (@(posedge clock) disable iff (!nrst)
        !isDirect && state_reg == ST_FALL ##1 state_reg == ST_RISE);
    cov_alert: cover property (@(posedge clock) disable iff (!nrst) alert);

endmodule : led_duty_ramp

// file: tb/led_duty_ramp_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, got, exp); end end

module led_duty_ramp_tb;
    import led_duty_pkg::*;
    localparam int MS = 1;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic [1:0] behaviour = 2'h0;
    logic actuate = 1'b0;
    logic byDriveBit = 1'b0;
    logic rampAlertEn = 1'b0;
    logic [7:0] regRdData;
    logic pwmOut;
    logic [6:0] dutyLevel;
    logic alert;
    int n_fail = 0;
    int compares = 0;
    int seed = 6829;
    int alertCount = 0;

    always #2.5 clock = ~clock;

    always @(posedge clock)
        if (alert === 1'b1)
            alertCount <= alertCount + 1;

    led_duty_ramp #(.MS_CYCLES(MS)) i_dut (.clock(clock), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
        .behaviour(behaviour), .actuate(actuate), .byDriveBit(byDriveBit),
        .rampAlertEn(rampAlertEn), .pwmOut(pwmOut), .dutyLevel(dutyLevel), .alert(alert));

    function automatic logic [6:0] upperPct(input logic [3:0] c);
        logic [6:0] t [16];
        t = '{7'h07, 7'h09, 7'h0B, 7'h0E, 7'h11, 7'h14, 7'h17, 7'h1A,
              7'h1E, 7'h23, 7'h28, 7'h2E, 7'h35, 7'h3F, 7'h4D, 7'h64};
        return t[c];
    endfunction : upperPct

    function automatic logic [6:0] lowerPct(input logic [3:0] c);
        return (c == 4'h0) ? 7'h00 : upperPct(c - 4'h1);
    endfunction : lowerPct

    function automatic int rampMs(input int c);
        return (c == 7) ? 2000 : c * 250;
    endfunction : rampMs

    function automatic int delayMs(input int c);
        return (c <= 4) ? c * 500 : (c - 2) * 1000;
    endfunction : delayMs

    task automatic give_verdict();
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clock);
        regWrEn = 1'b0;
    endtask : regWrite

    task automatic regCheck(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        regAddr = a;
        @(negedge clock);
        `CHK(regRdData, exp)
    endtask : regCheck

    // Waits for a duty level, counting cycles; dir 1 rising, 2 falling
    task automatic waitDuty(input logic [6:0] v, input int bound, input int dir, output int n);
        logic [6:0] prev;
        int bad;
        n = 0;
        bad = 0;
        prev = dutyLevel;
        while (dutyLevel !== v)
        begin
            @(negedge clock);
            n++;
            if ((dir == 1 && dutyLevel < prev) || (dir == 2 && dutyLevel > prev))
                bad++;
            prev = dutyLevel;
            if (n > bound)
            begin
                n_fail++;
                give_verdict();
            end
        end
        `CHK(bad, 0)
    endtask : waitDuty

    task automatic pwmCount(input int len, output int n);
        n = 0;
        repeat (len)
        begin
            @(negedge clock);
            if (pwmOut === 1'b1)
                n++;
        end
    endtask : pwmCount

    initial
    begin
        int n;
        int t;
        int a;
        logic [3:0] u;
        logic [7:0] d;
        logic [7:0] e;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            for (a = 0; a < 6; a++)
                regCheck(8'h90 + a[7:0], (a < 4) ? 8'hF0 : 8'h00);
            regCheck(8'h96, 8'h00);
            if (p == 0)
            begin
                for (a = 0; a < 7; a++)
                begin
                    d = $random(seed);
                    regWrite(8'h90 + a[7:0], d);
                    e = (a == 4) ? (d & 8'h3F) : (a == 5) ? (d & 8'h07) : (a == 6) ? 8'h00 : d;
                    regCheck(8'h90 + a[7:0], e);
                end
                @(negedge clock);
                nrst = 1'b0;
                repeat (2) @(negedge clock);
                nrst = 1'b1;
            end
        end
        // Zero ramp times: fast PWM, every duty code
        for (int i = 0; i < 16; i++)
        begin
            regWrite(8'h93, {i[3:0], i[3:0]});
            rampAlertEn = $random(seed);
            byDriveBit = $random(seed);
            alertCount = 0;
            @(negedge clock);
            actuate = 1'b1;
            waitDuty(upperPct(i[3:0]), 10, 0, n);
            `CHK(n <= 4, 1'b1)
            repeat (5) @(negedge clock);
            pwmCount(100, t);
            `CHK(t, int'(upperPct(i[3:0])))
            u = (i == 15) ? 4'hE : 4'hF;
            regWrite(8'h93, {u, i[3:0]});
            waitDuty(upperPct(u), 8, 0, n);
            `CHK(dutyLevel, upperPct(u))
            @(negedge clock);
            actuate = 1'b0;
            waitDuty(lowerPct(i[3:0]), 10, 0, n);
            `CHK(dutyLevel, lowerPct(i[3:0]))
            repeat (6) @(negedge clock);
            `CHK(alertCount, (rampAlertEn && byDriveBit) ? 1 : 0)
        end
        // Direct rise, hold, off delay and fall timing
        regWrite(8'h93, 8'hE0);
        for (int k = 0; k < 8; k++)
        begin
            regWrite(8'h94, {2'b00, k[2:0], 3'(7 - k)});
            regWrite(8'h95, {5'b00000, k[2:0]});
            @(negedge clock);
            actuate = 1'b1;
            waitDuty(7'h4D, rampMs(k) * MS + 20, 1, n);
            `CHK(n >= rampMs(k) * MS - MS && n <= rampMs(k) * MS + 6, 1'b1)
            regWrite(8'h94, {2'b00, 3'(7 - k), 3'(7 - k)});
            if (k == 3)
            begin
                pwmCount(800, t);
                `CHK(t, 8 * 77)
            end
            repeat (20) @(negedge clock);
            `CHK(dutyLevel, 7'h4D)
            @(negedge clock);
            actuate = 1'b0;
            t = delayMs(k) * MS;
            if (t > 2)
            begin
                repeat (t - 2) @(negedge clock);
                `CHK(dutyLevel, 7'h4D)
            end
            waitDuty(7'h00, (delayMs(k) + rampMs(7 - k)) * MS + 20, 2, n);
            n = n + ((t > 2) ? t - 2 : 0);
            t = (delayMs(k) + rampMs(7 - k)) * MS;
            `CHK(n >= t - MS && n <= t + 8, 1'b1)
        end
        // Latched limits in pulse 1, pulse 2 and breathe modes
        for (int b = 1; b < 4; b++)
        begin
            regWrite(8'h8F + b[7:0], 8'hF0);
            @(negedge clock);
            behaviour = b[1:0];
            actuate = 1'b1;
            regWrite(8'h8F + b[7:0], 8'h51);
            waitDuty(7'h64, 1000 * MS + 20, 1, n);
            `CHK(dutyLevel, 7'h64)
            waitDuty(7'h00, 1000 * MS + 20, 2, n);
            `CHK(dutyLevel, 7'h00)
            @(negedge clock);
            actuate = 1'b0;
            // Released as the next rise starts from the bottom: the run still climbs, then ends at the lower limit
            waitDuty(7'h64, 1000 * MS + 20, 1, n);
            waitDuty(7'h00, 1000 * MS + 20, 2, n);
            repeat (100) @(negedge clock);
            `CHK(dutyLevel, 7'h00)
            actuate = 1'b1;
            waitDuty(7'h14, 1000 * MS + 20, 0, n);
            @(negedge clock);
            actuate = 1'b0;
            waitDuty(7'h07, 1000 * MS + 20, 0, n);
            `CHK(dutyLevel, 7'h07)
        end
        give_verdict();
    end
endmodule : led_duty_ramp_tb
